// ### inc/usl_map.svh
// register offsets, field positions, reset values and timing constants
`ifndef USL_MAP_SVH
`define USL_MAP_SVH
`define USL_ADDR_W          8
`define USL_OFS_STATUS_CTL  8'h68
`define USL_OFS_SHORT_HOLD  8'h6C
`define USL_OFS_RX_LEVEL    8'h70
`define USL_ALWAYS_BIT      31
`define USL_EN_HI           19
`define USL_EN_W            20
`define USL_HOLD_W          16
`define USL_HOLD_RST        16'h0800
`define USL_LVL_W           14
`define USL_DRAIN_LSB       16
`define USL_HOLD_STEP_PS    16667
`define USL_CLK_PERIOD_PS   10000
`define USL_HOLD_CYC        ((`USL_HOLD_STEP_PS + `USL_CLK_PERIOD_PS - 1) / `USL_CLK_PERIOD_PS)
`endif

// ### inc/usl_pkg.sv
// types for the status endpoint, short packet hold and rx level block
package usl_pkg;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } usl_bus_t;

   typedef enum logic [1:0] {
      USL_IDLE,
      USL_WAIT,
      USL_SEND
   } usl_hold_state_t;

   typedef struct packed {
      logic            always_send;
      logic [19:0]     event_en;
      logic [19:0]     event_seen;
      logic            status_send;
      logic [15:0]     hold_val;
      usl_hold_state_t hold_st;
      logic [15:0]     hold_cnt;
      logic [1:0]      step_cnt;
      logic            short_go;
      logic [13:0]     drain_lvl;
      logic [13:0]     fill_lvl;
      logic [13:0]     wr_pkt_cnt;
      logic [13:0]     rd_pkt_cnt;
      logic            usb_rewind;
      logic [31:0]     rdata;
   } usl_state_t;
endpackage : usl_pkg

// ### logic/usl_core.sv
// status endpoint gating, short bulk-in hold and rx fifo level tracking
// Operation
// - always-send set: status packet every poll interval regardless of events
// - always-send clear (reset): send only after an enabled event occurred
// - bits 19..16 gate mac timeout, rx frame, tx halt, rx halt; reset 0
// - bits 15..11 gate phy, tx error, underrun, overrun, rx drop events
// - bits 10..0 gate each general-purpose pin event
// - short bulk-in packet waits programmed 16-bit delay, 16.667 ns steps rounded up to 2 clocks (20 ns), reset 800h
// - drain level rises by whole packet count once packet fully written
// - drain level falls by one per dword read
// - read rewind adds back dwords already read of current packet
// - usb error during send rewinds read data for retransmission
// - fill level rises by one per dword written
// - fill level drops by packet count after packet fully read
// - write rewind subtracts dwords already written of current packet
// - fcs error rewinds partially written frame out of fifo
// - both levels read-only, reset to zero
`timescale 1ns/1ps
`include "usl_map.svh"
module usl_core
   import usl_pkg::*;
(
   input  wire logic        I_CLOCK,        // 100 MHz clock
   input  wire logic        I_ARST_N,       // async reset, active low
   input  wire logic [7:0]  I_ADDR,         // register byte address
   input  wire logic [31:0] I_WDATA,        // write data
   input  wire logic        I_WR,           // write strobe
   input  wire logic        I_RD,           // read strobe
   input  wire logic [19:0] I_EVENTS,       // event pulses, bit order as enables
   input  wire logic        I_POLL,         // interrupt endpoint poll opportunity
   input  wire logic        I_SHORT_REQ,    // short bulk-in packet ready
   input  wire logic        I_WR_DWORD,     // one dword written to rx fifo
   input  wire logic        I_WR_EOP,       // last dword of packet written
   input  wire logic        I_FCS_ERR,      // frame error: rewind write side
   input  wire logic        I_RD_DWORD,     // one dword read from rx fifo
   input  wire logic        I_RD_EOP,       // last dword of packet read
   input  wire logic        I_USB_ERR,      // usb error: rewind read side
   output logic [31:0]      O_RDATA,        // read data, cycle after strobe
   output logic             O_STATUS_SEND,  // send status packet this poll
   output logic             O_SHORT_GO,     // short packet may be sent
   output logic             O_USB_REWIND,   // retransmit current packet
   output logic [13:0]      O_DRAIN_LVL,    // rx read-side level
   output logic [13:0]      O_FILL_LVL      // rx write-side level
);
   localparam logic [1:0] HOLD_CYC = 2'(`USL_HOLD_CYC);

   usl_state_t st_reg;
   usl_state_t st_next;
   wire logic [`USL_EN_HI:0] gated_ev;

   // per-event gate: an event counts only while its enable bit is set
   for (genvar g = 0; g < `USL_EN_W; g++)
   begin : g_event_gate
      assign gated_ev[g] = I_EVENTS[g] & st_reg.event_en[g];
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   always_comb
   begin
      logic [19:0] live;
      logic        req;
      logic [13:0] wr_cnt;
      logic [13:0] rd_cnt;
      st_next = st_reg;
      live = '0;
      req = 1'b0;
      wr_cnt = st_reg.wr_pkt_cnt;
      rd_cnt = st_reg.rd_pkt_cnt;
      st_next.usb_rewind = 1'b0;
      // register writes
      if (I_WR)
      begin
         if (hit(I_ADDR, `USL_OFS_STATUS_CTL))
         begin
            st_next.always_send = I_WDATA[`USL_ALWAYS_BIT];
            st_next.event_en = I_WDATA[`USL_EN_HI:0];
         end
         else if (hit(I_ADDR, `USL_OFS_SHORT_HOLD))
         begin
            st_next.hold_val = I_WDATA[`USL_HOLD_W-1:0];
         end
      end
      // register reads; unmapped reads return zero, levels have no write path
      st_next.rdata = '0;
      if (I_RD)
      begin
         if (hit(I_ADDR, `USL_OFS_STATUS_CTL))
         begin
            st_next.rdata[`USL_ALWAYS_BIT] = st_reg.always_send;
            st_next.rdata[`USL_EN_HI:0] = st_reg.event_en;
         end
         else if (hit(I_ADDR, `USL_OFS_SHORT_HOLD))
         begin
            st_next.rdata[`USL_HOLD_W-1:0] = st_reg.hold_val;
         end
         else if (hit(I_ADDR, `USL_OFS_RX_LEVEL))
         begin
            st_next.rdata[`USL_DRAIN_LSB+`USL_LVL_W-1:`USL_DRAIN_LSB] = st_reg.drain_lvl;
            st_next.rdata[`USL_LVL_W-1:0] = st_reg.fill_lvl;
         end
      end
      // event gating: only enabled events are latched, new events beat the poll clear
      live = gated_ev;
      req = |st_reg.event_seen;
      st_next.status_send = 1'b0;
      if (I_POLL)
      begin
         st_next.status_send = st_reg.always_send | req;
         st_next.event_seen = live;
      end
      else
      begin
         st_next.event_seen = st_reg.event_seen | live;
      end
      // short packet hold timer
      st_next.short_go = 1'b0;
      case (st_reg.hold_st)
         USL_IDLE:
         begin
            if (I_SHORT_REQ)
            begin
               st_next.hold_cnt = st_reg.hold_val;
               st_next.step_cnt = '0;
               st_next.hold_st = USL_WAIT;
            end
         end
         USL_WAIT:
         begin
            if (st_reg.hold_cnt == '0)
            begin
               st_next.hold_st = USL_SEND;
            end
            else if (st_reg.step_cnt == HOLD_CYC - 2'h1)
            begin
               st_next.step_cnt = '0;
               st_next.hold_cnt = st_reg.hold_cnt - 16'h0001;
            end
            else
            begin
               st_next.step_cnt = st_reg.step_cnt + 2'h1;
            end
         end
         USL_SEND:
         begin
            st_next.short_go = 1'b1;
            st_next.hold_st = USL_IDLE;
         end
         default:
         begin
            st_next.hold_st = USL_IDLE;
         end
      endcase
      // write side accounting
      if (I_FCS_ERR)
      begin
         st_next.fill_lvl = st_reg.fill_lvl - st_reg.wr_pkt_cnt;
         wr_cnt = '0;
      end
      else if (I_WR_DWORD)
      begin
         wr_cnt = st_reg.wr_pkt_cnt + 14'h0001;
         st_next.fill_lvl = st_reg.fill_lvl + 14'h0001;
      end
      // read side accounting
      if (I_USB_ERR)
      begin
         st_next.drain_lvl = st_reg.drain_lvl + st_reg.rd_pkt_cnt;
         rd_cnt = '0;
         st_next.usb_rewind = 1'b1;
      end
      else if (I_RD_DWORD)
      begin
         rd_cnt = st_reg.rd_pkt_cnt + 14'h0001;
         st_next.drain_lvl = st_reg.drain_lvl - 14'h0001;
      end
      if (!I_FCS_ERR && I_WR_DWORD && I_WR_EOP)
      begin
         st_next.drain_lvl = st_next.drain_lvl + wr_cnt;
         wr_cnt = '0;
      end
      if (!I_USB_ERR && I_RD_DWORD && I_RD_EOP)
      begin
         st_next.fill_lvl = st_next.fill_lvl - rd_cnt;
         rd_cnt = '0;
      end
      st_next.wr_pkt_cnt = wr_cnt;
      st_next.rd_pkt_cnt = rd_cnt;
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         st_reg <= '0;
         st_reg.hold_val <= `USL_HOLD_RST;
         st_reg.hold_st <= USL_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign O_RDATA = st_reg.rdata;
   assign O_STATUS_SEND = st_reg.status_send;
   assign O_SHORT_GO = st_reg.short_go;
   assign O_USB_REWIND = st_reg.usb_rewind;
   assign O_DRAIN_LVL = st_reg.drain_lvl;
   assign O_FILL_LVL = st_reg.fill_lvl;

   // poll steps: one that must answer, one that must stay silent
   sequence s_poll_always;
      I_POLL && st_reg.always_send;
   endsequence

   sequence s_poll_idle;
      I_POLL && !st_reg.always_send && st_reg.event_seen == '0;
   endsequence

   // an enabled event, a quiet cycle, then the poll that must serve it
   sequence s_event_then_poll;
      (I_EVENTS & st_reg.event_en) != '0 && !I_POLL ##1 !I_POLL ##1 I_POLL;
   endsequence

   // short hold steps: request taken in idle, quiet wait, then the release pulse
   sequence s_hold_one;
      st_reg.hold_st == USL_IDLE && I_SHORT_REQ && st_reg.hold_val == 16'h0001;
   endsequence

   sequence s_hold_none;
      st_reg.hold_st == USL_IDLE && I_SHORT_REQ && st_reg.hold_val == 16'h0000;
   endsequence

   sequence s_release_after_four;
      !O_SHORT_GO [*4] ##1 O_SHORT_GO;
   endsequence

   sequence s_release_after_two;
      !O_SHORT_GO [*2] ##1 O_SHORT_GO;
   endsequence

   // whole packets ending on one side with nothing else moving
   sequence s_packet_written;
      I_WR_DWORD && I_WR_EOP && !I_FCS_ERR && !I_RD_DWORD && !I_USB_ERR;
   endsequence

   sequence s_packet_read;
      I_RD_DWORD && I_RD_EOP && !I_USB_ERR && !I_WR_DWORD && !I_FCS_ERR;
   endsequence

   AST_ALWAYS_SEND: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_poll_always
      |=> O_STATUS_SEND)
      else $error("always-send poll produced no status packet");

   AST_NO_EVENT_NO_SEND: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_poll_idle
      |=> !O_STATUS_SEND)
      else $error("status packet without enabled event");

   AST_MASKED_EVENT: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !I_POLL && (I_EVENTS & ~st_reg.event_en) != '0 && (I_EVENTS & st_reg.event_en) == '0
      |=> st_reg.event_seen == $past(st_reg.event_seen))
      else $error("disabled event was latched");

   AST_ENABLED_EVENT: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_event_then_poll
      |=> O_STATUS_SEND)
      else $error("enabled event did not reach next poll");

   AST_STATUS_ON_POLL: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      O_STATUS_SEND
      |-> $past(I_POLL))
      else $error("status packet outside a poll");

   AST_EVENT_CLEAR: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_POLL && (I_EVENTS & st_reg.event_en) == '0
      |=> st_reg.event_seen == '0)
      else $error("served event was not cleared");

   AST_HOLD_TIME: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_hold_one
      |=> s_release_after_four)
      else $error("short packet hold length wrong");

   AST_HOLD_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_hold_none
      |=> s_release_after_two)
      else $error("zero short packet hold length wrong");

   AST_SHORT_PULSE: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      O_SHORT_GO
      |=> !O_SHORT_GO)
      else $error("short packet release longer than one cycle");

   AST_PACKET_IN: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_packet_written
      |=> O_DRAIN_LVL == $past(O_DRAIN_LVL) + $past(st_reg.wr_pkt_cnt) + 14'h0001
      && O_FILL_LVL == $past(O_FILL_LVL) + 14'h0001)
      else $error("drain level did not take the whole packet");

   AST_DRAIN_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !I_RD_DWORD && !I_USB_ERR && !(I_WR_DWORD && I_WR_EOP)
      |=> $stable(O_DRAIN_LVL))
      else $error("drain level moved without a packet end");

   AST_DRAIN_DEC: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_RD_DWORD && !I_RD_EOP && !I_USB_ERR && !(I_WR_DWORD && I_WR_EOP)
      |=> O_DRAIN_LVL == $past(O_DRAIN_LVL) - 14'h0001)
      else $error("drain level did not count a read");

   AST_READ_REWIND: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_USB_ERR && !(I_WR_DWORD && I_WR_EOP && !I_FCS_ERR)
      |=> O_USB_REWIND && O_DRAIN_LVL == $past(O_DRAIN_LVL) + $past(st_reg.rd_pkt_cnt))
      else $error("read rewind did not restore dwords");

   AST_REWIND_PULSE: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      O_USB_REWIND
      |-> $past(I_USB_ERR))
      else $error("retransmit request without usb error");

   AST_FILL_INC: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_WR_DWORD && !I_WR_EOP && !I_FCS_ERR && !I_RD_DWORD && !I_USB_ERR
      |=> O_FILL_LVL == $past(O_FILL_LVL) + 14'h0001)
      else $error("fill level did not count a write");

   AST_PACKET_OUT: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_packet_read
      |=> O_FILL_LVL == $past(O_FILL_LVL) - $past(st_reg.rd_pkt_cnt) - 14'h0001)
      else $error("fill level did not drop the whole packet");

   AST_WRITE_REWIND: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_FCS_ERR && !(I_RD_DWORD && I_RD_EOP && !I_USB_ERR)
      |=> O_FILL_LVL == $past(O_FILL_LVL) - $past(st_reg.wr_pkt_cnt))
      else $error("write rewind did not drop dwords");

   AST_FILL_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !I_WR_DWORD && !I_FCS_ERR && !(I_RD_DWORD && I_RD_EOP)
      |=> $stable(O_FILL_LVL))
      else $error("fill level moved without fifo traffic");

   AST_READ_LEVELS: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_RD && I_ADDR == `USL_OFS_RX_LEVEL
      |=> O_RDATA == {2'h0, $past(O_DRAIN_LVL), 2'h0, $past(O_FILL_LVL)})
      else $error("level register read wrong");
endmodule : usl_core

// ### sim/usl_host_model.sv
// usb host side: polls the status endpoint and requests short bulk-in packets
`timescale 1ns/1ps
module usl_host_model (
   input  wire logic i_clock,        // bench clock
   input  wire logic i_status_send,  // status packet flag from the block
   input  wire logic i_short_go,     // short packet release from the block
   output logic      o_poll,         // poll opportunity pulse
   output logic      o_short_req     // short packet waiting pulse
);
   initial o_poll = 1'b0;
   initial o_short_req = 1'b0;

   // one poll; the answer stands only in the cycle after it
   task automatic poll(output logic sent);
      @(posedge i_clock);
      o_poll <= 1'b1;
      @(posedge i_clock);
      o_poll <= 1'b0;
      #1 sent = i_status_send;
   endtask : poll

   // cycles from the request cycle to the release, bounded
   task automatic short_wait(output int cyc);
      @(posedge i_clock);
      o_short_req <= 1'b1;
      @(posedge i_clock);
      o_short_req <= 1'b0;
      cyc = 0;
      #1;
      while (i_short_go !== 1'b1 && cyc < 5000)
      begin
         @(posedge i_clock);
         #1 cyc++;
      end
   endtask : short_wait
endmodule : usl_host_model

// ### sim/usl_core_bench.sv
// self-checking bench for the status, short hold and rx level block
`timescale 1ns/1ps
`include "usl_map.svh"
module usl_core_bench;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, poll, sreq, stat, go, s;
   logic        wd = 1'b0, we = 1'b0, fe = 1'b0, rdw = 1'b0, re = 1'b0, ue = 1'b0, rew;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [19:0] ev = 20'h0;
   logic [13:0] drain, fill;
   int          errors = 0, checks = 0, n;

   initial forever #5 clk = ~clk;

   usl_core u_usl_core (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .I_EVENTS(ev), .I_POLL(poll), .I_SHORT_REQ(sreq),
      .I_WR_DWORD(wd), .I_WR_EOP(we), .I_FCS_ERR(fe), .I_RD_DWORD(rdw), .I_RD_EOP(re),
      .I_USB_ERR(ue), .O_RDATA(rdata), .O_STATUS_SEND(stat), .O_SHORT_GO(go),
      .O_USB_REWIND(rew), .O_DRAIN_LVL(drain), .O_FILL_LVL(fill));
   usl_host_model u_host (.i_clock(clk), .i_status_send(stat), .i_short_go(go),
      .o_poll(poll), .o_short_req(sreq));

   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp32

   task automatic cmp1(input string what, input logic exp, input logic seen);
      cmp32(what, {31'h0, exp}, {31'h0, seen});
   endtask : cmp1

   task automatic close_out;
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp32("register", exp, rdata);
   endtask : rd_chk

   task automatic pulse_ev(input logic [19:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 20'h0;
   endtask : pulse_ev

   // n dwords on the write side (side 0) or read side (side 1)
   task automatic move(input logic side, input int cnt, input logic eop);
      for (int k = 0; k < cnt; k++)
      begin
         @(posedge clk);
         wd <= !side;
         rdw <= side;
         we <= !side && eop && k == cnt - 1;
         re <= side && eop && k == cnt - 1;
      end
      @(posedge clk);
      {wd, rdw, we, re} <= 4'h0;
   endtask : move

   task automatic err(input logic side);
      @(posedge clk);
      fe <= !side;
      ue <= side;
      @(posedge clk);
      fe <= 1'b0;
      ue <= 1'b0;
      #1 cmp1("usb rewind", side, rew);
   endtask : err

   task automatic lvl(input logic [13:0] d, input logic [13:0] f);
      #1 cmp32("levels", {2'h0, d, 2'h0, f}, {2'h0, drain, 2'h0, fill});
   endtask : lvl

   initial
   begin
      #100000;
      errors++;
      close_out();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(`USL_OFS_STATUS_CTL, 32'h0);
      rd_chk(`USL_OFS_SHORT_HOLD, 32'h0000_0800);
      rd_chk(`USL_OFS_RX_LEVEL, 32'h0);
      rd_chk(8'h74, 32'h0);
      u_host.short_wait(n);
      cmp32("hold cycles", 32'h0000_1002, 32'(n));
      foreach (ev[h])
      begin
         if (h < 3)
         begin
            wr_reg(`USL_OFS_SHORT_HOLD, 32'(h));
            u_host.short_wait(n);
            cmp32("hold cycles", 32'(h * 2 + 2), 32'(n));
         end
      end
      wr_reg(`USL_OFS_STATUS_CTL, 32'hFFFF_FFFF);
      rd_chk(`USL_OFS_STATUS_CTL, 32'h800F_FFFF);
      wr_reg(`USL_OFS_STATUS_CTL, 32'h8000_0000);
      repeat (2)
      begin
         u_host.poll(s);
         cmp1("always send", 1'b1, s);
      end
      for (int i = 0; i < `USL_EN_W; i++)
      begin
         wr_reg(`USL_OFS_STATUS_CTL, 32'h1 << i);
         u_host.poll(s);
         pulse_ev(~(20'h1 << i));
         u_host.poll(s);
         cmp1("blocked event", 1'b0, s);
         pulse_ev(20'h1 << i);
         u_host.poll(s);
         cmp1("enabled event", 1'b1, s);
         u_host.poll(s);
         cmp1("served event", 1'b0, s);
      end
      move(1'b0, 2, 1'b0);
      lvl(14'h0, 14'h2);
      move(1'b0, 1, 1'b1);
      lvl(14'h3, 14'h3);
      rd_chk(`USL_OFS_RX_LEVEL, 32'h0003_0003);
      move(1'b1, 2, 1'b0);
      lvl(14'h1, 14'h3);
      err(1'b1);
      lvl(14'h3, 14'h3);
      move(1'b1, 3, 1'b1);
      lvl(14'h0, 14'h0);
      move(1'b0, 2, 1'b0);
      err(1'b0);
      lvl(14'h0, 14'h0);
      wr_reg(`USL_OFS_RX_LEVEL, 32'hFFFF_FFFF);
      rd_chk(`USL_OFS_RX_LEVEL, 32'h0);
      move(1'b0, 2, 1'b0);
      lvl(14'h0, 14'h2);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      lvl(14'h0, 14'h0);
      rd_chk(`USL_OFS_SHORT_HOLD, 32'h0000_0800);
      rd_chk(`USL_OFS_STATUS_CTL, 32'h0);
      close_out();
   end
endmodule : usl_core_bench
